/* File: rtl/atc_cfg.svh */
/*
  Offsets, field positions, reset values and timing counts of the acquisition trigger block.
  Assumes inclusion by bare name from the package and the design modules.
*/
// How it works
// RULE1 - Immediate source fires trigger on start
// RULE2 - Phase source waits for phase A angle
// RULE3 - Phase fires on first match after arming
// RULE4 - Phases A B C offset 0 240 120
// RULE5 - Voltage step programs output and triggers together
// RULE6 - Step updates selected phase or all three
// RULE7 - Voltage step waits for closed output relay
// RULE8 - Positive delay holds off capture after trigger
// RULE9 - Positive delay zero to one second steps
// RULE10 - Negative delay limited to window depth
// RULE11 - Negative delay buffers samples before trigger
// RULE12 - Fixed mode applies new voltage immediately
// RULE13 - Local panel forces maximum slew rates
// RULE14 - Power-up resets slew rates to maximum
// RULE15 - Step mode holds triggered value permanently
// RULE16 - Pulse mode drives value for pulse time
// RULE17 - List mode steps through list points
// RULE18 - Fixed mode disables transient behaviour
// RULE19 - Single mode arms once, idles after capture
// RULE20 - Continuous mode re-arms after every trigger
// RULE21 - Source is two-bit code, fourth reserved
// RULE22 - Delay is signed count of 0.1 ms
// RULE23 - Start while armed restarts arming
`ifndef ATC_CFG_SVH
`define ATC_CFG_SVH

`define ATC_ADDR_CTRL      12'h000
`define ATC_ADDR_DELAY     12'h004
`define ATC_ADDR_PHASE     12'h008
`define ATC_ADDR_SETVOLT   12'h00c
`define ATC_ADDR_VOLT      12'h010
`define ATC_ADDR_SLEW      12'h014
`define ATC_ADDR_PULSE     12'h018
`define ATC_ADDR_STATUS    12'h01c
`define ATC_ADDR_OUTVOLT   12'h020

`define ATC_CTRL_START_BIT  0
`define ATC_CTRL_AUTO_REARM_ARMING_BIT   1
`define ATC_CTRL_SRC_LSB    2
`define ATC_CTRL_MODE_LSB   4
`define ATC_CTRL_PHSEL_LSB  6
`define ATC_CTRL_THREE_BIT  8

`define ATC_SLEW_MAX        16'hffff
`define ATC_DELAY_RESET     16'h0000
`define ATC_DELAY_POS_MAX   16'd10000
`define ATC_DELAY_NEG_1PH   16'd4260
`define ATC_DELAY_NEG_3PH   16'd12800
`define ATC_PHASE_B_OFS     9'd240
`define ATC_PHASE_C_OFS     9'd120
`define ATC_PHASE_FULL      9'd360

`define ATC_CLK_HZ          25000000
`define ATC_TICK_US         100
`define ATC_TICK_CYC        ((`ATC_CLK_HZ / 1000000) * `ATC_TICK_US)

`endif

/* File: rtl/atc_pkg.sv */
/*
  Types shared by the acquisition trigger block.
  Includes the constants header itself by bare name, ahead of the package.
*/
`include "atc_cfg.svh"
package atc_pkg;
  typedef enum logic [1:0] {
    ATC_SRC_IMM   = 2'h0,
    ATC_SRC_PHASE = 2'h1,
    ATC_SRC_STEP  = 2'h2,
    ATC_SRC_RSVD  = 2'h3
  } atc_src_e;

  typedef enum logic [1:0] {
    ATC_MODE_FIXED = 2'h0,
    ATC_MODE_STEP  = 2'h1,
    ATC_MODE_PULSE = 2'h2,
    ATC_MODE_LIST  = 2'h3
  } atc_mode_e;

  typedef enum logic [1:0] {
    ATC_ST_IDLE  = 2'b00,
    ATC_ST_ARMED = 2'b01,
    ATC_ST_HOLD  = 2'b11,
    ATC_ST_CAPT  = 2'b10
  } atc_state_e;
endpackage

/* File: rtl/atc_tick.sv */
/*
  Divider that produces one pulse every 0.1 ms from the system clock.
  Assumes a free-running clock at the rate set in the constants header.
*/
`timescale 1ns/10ps
`include "atc_cfg.svh"
module atc_tick #(
  parameter int TICK_CYC = `ATC_TICK_CYC
) (
  input  wire logic clock_i,
  input  wire logic rst_b_i,
  output logic      tick_o
);
  logic [15:0] cnt_reg;
  wire         wrap = (cnt_reg == 16'(TICK_CYC - 1));

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) cnt_reg <= 16'h0000;
    else cnt_reg <= wrap ? 16'h0000 : cnt_reg + 16'h0001;
  end

  assign tick_o = wrap;
endmodule

/* File: rtl/atc_phase_match.sv */
/*
  Detects the moment phase A reaches the programmed trigger phase angle.
  Assumes phase_a_i counts 0..359 degrees on the same clock.
*/
`timescale 1ns/10ps
`include "atc_cfg.svh"
module atc_phase_match (
  input  wire logic       clock_i,
  input  wire logic       rst_b_i,
  input  wire logic [8:0] phase_a_i,
  input  wire logic [8:0] target_i,
  output logic            hit_o,
  output logic [8:0]      phase_b_o,
  output logic [8:0]      phase_c_o
);
  logic [8:0] prev_reg;

  function automatic logic [8:0] wrap_add(input logic [8:0] a, input logic [8:0] b);
    logic [9:0] s;
    s = {1'b0, a} + {1'b0, b};
    wrap_add = (s >= {1'b0, `ATC_PHASE_FULL}) ? 9'(s - {1'b0, `ATC_PHASE_FULL}) : s[8:0];
  endfunction

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) prev_reg <= 9'h000;
    else prev_reg <= phase_a_i;
  end

  // A crossing counts when the target lies in (prev, now], wrap included.
  wire wrapped = phase_a_i < prev_reg;
  assign hit_o = wrapped ? (target_i > prev_reg || target_i <= phase_a_i)
                         : (target_i > prev_reg && target_i <= phase_a_i); // RULE2
  assign phase_b_o = wrap_add(target_i, `ATC_PHASE_B_OFS); // RULE4
  assign phase_c_o = wrap_add(target_i, `ATC_PHASE_C_OFS); // RULE4
endmodule

/* File: rtl/atc_top.sv */
/*
  Acquisition trigger and positioning control with output transient-mode selection.
  Assumes an APB master on clock_i, phase A angle and relay state from synchronous logic,
  and the local-panel strap as an asynchronous pin.
*/
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
`include "atc_cfg.svh"
module atc_top #(
  parameter int TICK_CYC = `ATC_TICK_CYC,
  parameter int PULSE_W  = 16
) (
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic [8:0]  phase_a_i,
  input  wire logic        relay_closed_i,
  input  wire logic        local_panel_i,
  input  wire logic        sample_i,
  input  wire logic        list_done_i,
  output logic             trigger_o,
  output logic             capture_o,
  output logic             pretrig_buffer_o,
  output logic [15:0]      volt_a_o,
  output logic [15:0]      volt_b_o,
  output logic [15:0]      volt_c_o,
  output logic [15:0]      volt_slew_o,
  output logic [15:0]      freq_slew_o,
  output logic             transient_go_o,
  output logic             list_step_o,
  output logic [8:0]       phase_b_o,
  output logic [8:0]       phase_c_o
);
  atc_pkg::atc_state_e state_reg, state_next;
  logic             auto_rearm_arming_reg;
  logic [1:0]       src_reg;
  logic [1:0]       mode_reg;
  logic [1:0]       phsel_reg;
  logic             three_reg;
  logic [15:0]      delay_reg;
  logic [8:0]       tphase_reg;
  logic [15:0]      setvolt_reg;
  logic [15:0]      fixvolt_reg;
  logic [15:0]      vslew_reg;
  logic [15:0]      fslew_reg;
  logic [PULSE_W-1:0] pulse_len_reg;
  logic [PULSE_W-1:0] pulse_cnt_reg;
  logic [15:0]      hold_cnt_reg;
  logic [15:0]      va_reg;
  logic [15:0]      vb_reg;
  logic [15:0]      vc_reg;
  logic [15:0]      base_a_reg;
  logic [15:0]      base_b_reg;
  logic [15:0]      base_c_reg;
  logic             pulse_on_reg;
  logic             trig_reg;
  logic             capt_reg;
  logic             capt_count_reg;
  logic             lp_s1_reg;
  logic             lp_s2_reg;
  logic [31:0]      rdata_reg;

  wire tick;
  wire phase_hit;

  function automatic logic [15:0] neg16(input logic [15:0] v);
    neg16 = 16'(~v + 16'h0001);
  endfunction

  function automatic logic phase_upd(input logic [1:0] sel, input logic [1:0] idx);
    phase_upd = (sel == idx) || (sel == 2'h3);
  endfunction

  atc_tick #(.TICK_CYC(TICK_CYC)) u_tick (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .tick_o  (tick)
  );

  atc_phase_match u_phase (
    .clock_i   (clock_i),
    .rst_b_i   (rst_b_i),
    .phase_a_i (phase_a_i),
    .target_i  (tphase_reg),
    .hit_o     (phase_hit),
    .phase_b_o (phase_b_o),
    .phase_c_o (phase_c_o)
  );

  // Two-flop synchroniser for the panel strap pin.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lp_s1_reg <= 1'b0;
      lp_s2_reg <= 1'b0;
    end else begin
      lp_s1_reg <= local_panel_i;
      lp_s2_reg <= lp_s1_reg;
    end
  end

  // APB decode; every access completes in its first access cycle.
  wire acc      = psel_i && penable_i;
  wire wr       = acc && pwrite_i;

  wire hit_ctrl = paddr_i == `ATC_ADDR_CTRL;
  wire hit_dly  = paddr_i == `ATC_ADDR_DELAY;
  wire hit_ph   = paddr_i == `ATC_ADDR_PHASE;
  wire hit_sv   = paddr_i == `ATC_ADDR_SETVOLT;
  wire hit_v    = paddr_i == `ATC_ADDR_VOLT;
  wire hit_sl   = paddr_i == `ATC_ADDR_SLEW;
  wire hit_pl   = paddr_i == `ATC_ADDR_PULSE;
  wire hit_st   = paddr_i == `ATC_ADDR_STATUS;
  wire hit_ov   = paddr_i == `ATC_ADDR_OUTVOLT;

  wire mapped   = hit_ctrl | hit_dly | hit_ph | hit_sv | hit_v | hit_sl | hit_pl
                | hit_st | hit_ov;

  wire start    = wr && hit_ctrl && pwdata_i[`ATC_CTRL_START_BIT];

  // Delay sign picks pre-trigger or post-trigger; range clamps at write time.
  wire        dly_neg   = pwdata_i[15];
  wire [15:0] dly_mag   = dly_neg ? neg16(pwdata_i[15:0]) : pwdata_i[15:0];
  wire [15:0] neg_lim   = three_reg ? `ATC_DELAY_NEG_3PH : `ATC_DELAY_NEG_1PH;
  wire [15:0] dly_pos_c = (dly_mag > `ATC_DELAY_POS_MAX) ? `ATC_DELAY_POS_MAX : dly_mag; // RULE9
  wire [15:0] dly_neg_c = (dly_mag > neg_lim) ? neg16(neg_lim)
                                              : pwdata_i[15:0]; // RULE10
  wire [15:0] dly_wr    = dly_neg ? dly_neg_c : dly_pos_c; // RULE22

  wire        neg_delay = delay_reg[15];

  // Trigger qualification per source.
  wire fire_cond = (src_reg == atc_pkg::ATC_SRC_IMM)   ? 1'b1 :                 // RULE1
                   (src_reg == atc_pkg::ATC_SRC_PHASE) ? phase_hit :            // RULE2
                   (src_reg == atc_pkg::ATC_SRC_STEP)  ? relay_closed_i : 1'b0; // RULE7 RULE21
  wire fire      = (state_reg == atc_pkg::ATC_ST_ARMED) && !start && fire_cond; // RULE3

  wire hold_done = (hold_cnt_reg == 16'h0000);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      atc_pkg::ATC_ST_IDLE: begin
        if (start) state_next = atc_pkg::ATC_ST_ARMED;
      end
      atc_pkg::ATC_ST_ARMED: begin
        if (start) state_next = atc_pkg::ATC_ST_ARMED; // RULE23
        else if (fire) state_next = atc_pkg::ATC_ST_HOLD;
      end
      atc_pkg::ATC_ST_HOLD: begin
        if (start) state_next = atc_pkg::ATC_ST_ARMED;
        else if (neg_delay || hold_done) state_next = atc_pkg::ATC_ST_CAPT; // RULE8
      end
      atc_pkg::ATC_ST_CAPT: begin
        if (start) state_next = atc_pkg::ATC_ST_ARMED;
        else if (sample_i) state_next = auto_rearm_arming_reg ? atc_pkg::ATC_ST_ARMED // RULE20
                                                 : atc_pkg::ATC_ST_IDLE; // RULE19
      end
      default: state_next = atc_pkg::ATC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= atc_pkg::ATC_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Hold-off counter in 0.1 ms ticks, loaded when the trigger fires.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hold_cnt_reg <= 16'h0000;
    end else if (fire) begin
      hold_cnt_reg <= neg_delay ? 16'h0000 : delay_reg; // RULE8
    end else if (tick && !hold_done) begin
      hold_cnt_reg <= hold_cnt_reg - 16'h0001;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trig_reg <= 1'b0;
      capt_reg <= 1'b0;
    end else begin
      trig_reg <= fire;
      capt_reg <= (state_next == atc_pkg::ATC_ST_CAPT);
    end
  end

  // Software registers.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      auto_rearm_arming_reg    <= 1'b0;
      src_reg     <= 2'h0;
      mode_reg    <= 2'h0;
      phsel_reg   <= 2'h3;
      three_reg   <= 1'b0;
      delay_reg   <= `ATC_DELAY_RESET;
      tphase_reg  <= 9'h000;
      setvolt_reg <= 16'h0000;
      pulse_len_reg <= '0;
      vslew_reg   <= `ATC_SLEW_MAX; // RULE14
      fslew_reg   <= `ATC_SLEW_MAX; // RULE14
    end else if (wr) begin
      if (hit_ctrl) begin
        auto_rearm_arming_reg  <= pwdata_i[`ATC_CTRL_AUTO_REARM_ARMING_BIT];
        src_reg   <= pwdata_i[`ATC_CTRL_SRC_LSB +: 2];
        mode_reg  <= pwdata_i[`ATC_CTRL_MODE_LSB +: 2];
        phsel_reg <= pwdata_i[`ATC_CTRL_PHSEL_LSB +: 2];
        three_reg <= pwdata_i[`ATC_CTRL_THREE_BIT];
      end
      if (hit_dly) begin
        delay_reg <= dly_wr;
      end
      if (hit_ph) begin
        tphase_reg <= (pwdata_i[8:0] >= `ATC_PHASE_FULL) ? 9'h000 : pwdata_i[8:0];
      end
      if (hit_sv) begin
        setvolt_reg <= pwdata_i[15:0];
      end
      if (hit_pl) begin
        pulse_len_reg <= pwdata_i[PULSE_W-1:0];
      end
      if (hit_sl) begin
        vslew_reg <= pwdata_i[15:0];
        fslew_reg <= pwdata_i[31:16];
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fixvolt_reg <= 16'h0000;
    end else if (wr && hit_v) begin
      fixvolt_reg <= pwdata_i[15:0];
    end
  end

  // Output voltage per phase.
  wire step_src  = (src_reg == atc_pkg::ATC_SRC_STEP);
  wire fixed     = (mode_reg == atc_pkg::ATC_MODE_FIXED);
  wire tr_fire   = fire && !fixed;                                     // RULE18
  wire upd_a     = phase_upd(phsel_reg, 2'h0); // RULE6
  wire upd_b     = phase_upd(phsel_reg, 2'h1); // RULE6
  wire upd_c     = phase_upd(phsel_reg, 2'h2); // RULE6
  wire pulse_end = pulse_on_reg && (pulse_cnt_reg == '0);

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      va_reg <= 16'h0000;
      vb_reg <= 16'h0000;
      vc_reg <= 16'h0000;
    end else if (wr && hit_v && fixed) begin
      va_reg <= pwdata_i[15:0]; // RULE12
      vb_reg <= pwdata_i[15:0];
      vc_reg <= pwdata_i[15:0];
    end else if (fire && step_src) begin
      if (upd_a) va_reg <= setvolt_reg; // RULE5
      if (upd_b) vb_reg <= setvolt_reg;
      if (upd_c) vc_reg <= setvolt_reg;
    end else if (pulse_end) begin
      va_reg <= base_a_reg; // RULE16
      vb_reg <= base_b_reg;
      vc_reg <= base_c_reg;
    end
  end

  // Pulse timing; step mode never restores, so it holds the value.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pulse_on_reg  <= 1'b0;
      pulse_cnt_reg <= '0;
      base_a_reg    <= 16'h0000;
      base_b_reg    <= 16'h0000;
      base_c_reg    <= 16'h0000;
    end else if (tr_fire && step_src && mode_reg == atc_pkg::ATC_MODE_PULSE) begin
      pulse_on_reg  <= 1'b1; // RULE16
      pulse_cnt_reg <= pulse_len_reg;
      base_a_reg    <= va_reg;
      base_b_reg    <= vb_reg;
      base_c_reg    <= vc_reg;
    end else if (pulse_end || fixed) begin
      pulse_on_reg  <= 1'b0; // RULE18
    end else if (pulse_on_reg && tick) begin
      pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      capt_count_reg <= 1'b0;
    end else begin
      capt_count_reg <= (mode_reg == atc_pkg::ATC_MODE_LIST) && !list_done_i
                        && (tr_fire || (capt_count_reg && !fixed)); // RULE17
    end
  end

  // Read mux.
  wire [31:0] ctrl_rd = {23'h000000, three_reg, phsel_reg, mode_reg, src_reg, auto_rearm_arming_reg, 1'b0};
  wire [31:0] stat_rd = {28'h0000000, pulse_on_reg, lp_s2_reg, state_reg};

  wire [31:0] rd_mux  = hit_ctrl ? ctrl_rd :
                        hit_dly  ? {16'h0000, delay_reg} :
                        hit_ph   ? {23'h000000, tphase_reg} :
                        hit_sv   ? {16'h0000, setvolt_reg} :
                        hit_v    ? {16'h0000, fixvolt_reg} :
                        hit_sl   ? {fslew_reg, vslew_reg} :
                        hit_pl   ? 32'(pulse_len_reg) :
                        hit_st   ? stat_rd :
                        hit_ov   ? {16'h0000, va_reg} : 32'h00000000;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_reg <= 32'h00000000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      rdata_reg <= rd_mux;
    end
  end

  assign prdata_o         = rdata_reg;
  assign pready_o         = 1'b1;
  assign pslverr_o        = acc && !mapped;

  assign trigger_o        = trig_reg;
  assign capture_o        = capt_reg;
  assign pretrig_buffer_o = neg_delay && (state_reg != atc_pkg::ATC_ST_IDLE); // RULE11
  assign volt_a_o         = va_reg;
  assign volt_b_o         = vb_reg;
  assign volt_c_o         = vc_reg;
  assign volt_slew_o      = lp_s2_reg ? `ATC_SLEW_MAX : vslew_reg; // RULE13
  assign freq_slew_o      = lp_s2_reg ? `ATC_SLEW_MAX : fslew_reg; // RULE13

  assign transient_go_o   = tr_fire && (mode_reg == atc_pkg::ATC_MODE_STEP); // RULE15
  assign list_step_o      = capt_count_reg;
endmodule

/* File: bench/atc_top_props.sv */
/*
  Concurrent checks on the acquisition trigger block, bound to its top module.
  Assumes one clock domain and the asynchronous active-low reset of the top module.
*/
`timescale 1ns/10ps
module atc_top_props (
  input wire logic        clock_i,
  input wire logic        rst_b_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        local_panel_i,
  input wire logic        sample_i,
  input wire logic        trigger_o,
  input wire logic        capture_o,
  input wire logic [15:0] volt_slew_o,
  input wire logic [15:0] freq_slew_o,
  input wire logic        transient_go_o,
  input wire logic [8:0]  phase_b_o,
  input wire logic [8:0]  phase_c_o
);
  wire acc_w = psel_i & penable_i;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  a_ready_high: assert property (pready_o)
    else $error("pready low");
  a_unmapped_err: assert property (acc_w && paddr_i > 12'h020 |-> pslverr_o)
    else $error("unmapped access without error");
  a_err_reads_zero: assert property (acc_w && pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
    else $error("refused read not zero");
  a_trig_pulse: assert property (trigger_o |=> !trigger_o)
    else $error("trigger longer than one cycle");
  a_capt_ends: assert property (capture_o && sample_i |=> !capture_o)
    else $error("capture not ended by sample");
  a_go_then_trig: assert property (transient_go_o |=> trigger_o)
    else $error("transient start without trigger");
  a_phase_spread: assert property ((phase_c_o + 9'd120) % 9'd360 == phase_b_o && phase_b_o < 9'd360)
    else $error("phase offsets wrong");
  a_panel_slew: assert property (local_panel_i [*4] |-> {volt_slew_o, freq_slew_o} == 32'hffffffff)
    else $error("panel slew not maximum");
  a_reset_slew: assert property ($rose(rst_b_i) |-> {volt_slew_o, freq_slew_o} == 32'hffffffff)
    else $error("slew not maximum after reset");
endmodule

bind atc_top atc_top_props u_props (.clock_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .prdata_o, .pready_o, .pslverr_o, .local_panel_i, .sample_i, .trigger_o,
  .capture_o, .volt_slew_o, .freq_slew_o, .transient_go_o, .phase_b_o, .phase_c_o);

/* File: bench/atc_apb_master.sv */
/*
  APB master standing in for the panel or bus controller that issues start.
  Assumes the bench holds req_i high until done_o has been seen.
*/
`timescale 1ns/10ps
module atc_apb_master (
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  input  wire logic        req_i,
  input  wire logic        wr_i,
  input  wire logic [11:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i,
  input  wire logic [31:0] prdata_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [11:0]      paddr_o,
  output logic [31:0]      pwdata_o,
  output logic [31:0]      rdata_o,
  output logic             err_o,
  output logic             done_o
);
  // The request stays put until pready is sampled, so a slow slave never loses it.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      psel_o    <= 1'b0;
      penable_o <= 1'b0;
      pwrite_o  <= 1'b0;
      paddr_o   <= 12'h000;
      pwdata_o  <= 32'h0;
      rdata_o   <= 32'h0;
      err_o     <= 1'b0;
      done_o    <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (penable_o && pready_i) begin
        psel_o    <= 1'b0;
        penable_o <= 1'b0;
        rdata_o   <= prdata_i;
        err_o     <= pslverr_i;
        done_o    <= 1'b1;
      end else if (psel_o) begin
        penable_o <= 1'b1;
      end else if (req_i && !done_o) begin
        psel_o   <= 1'b1;
        pwrite_o <= wr_i;
        paddr_o  <= addr_i;
        pwdata_o <= wdata_i;
      end
    end
  end
endmodule

/* File: bench/testbench.sv */
/*
  Self-checking bench for the acquisition trigger block.
  Assumes a tick of four clocks so trigger delays stay short.
*/
`timescale 1ns/10ps
module testbench;
  typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] x; logic e;} atc_row_s;
  logic clock_i, rst_b_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rdata, rd;
  logic [8:0] phase_a_i, phase_b_o, phase_c_o;
  logic relay_closed_i, local_panel_i, sample_i, list_done_i, trigger_o, capture_o;
  logic pretrig_buffer_o, transient_go_o, list_step_o, req, wr, done, err, er, spin, capt_q;
  logic [15:0] volt_a_o, volt_b_o, volt_c_o, volt_slew_o, freq_slew_o;
  logic [11:0] addr;
  logic [31:0] wdat;
  int num_errors, num_checks, nt, nc, ng;
  int cyc = 0, n_trig = 0, n_capt = 0, n_go = 0, t_trig = 0, t_capt = 0;
  atc_row_s rows [9] = '{'{12'h004, 32'h4e20, 32'h2710, 1'b0}, '{12'h004, 32'hec78, 32'hef5c, 1'b0},
    '{12'h004, 32'h3, 32'h3, 1'b0}, '{12'h008, 32'h5f, 32'h5f, 1'b0},
    '{12'h00c, 32'h555, 32'h555, 1'b0}, '{12'h010, 32'h1234, 32'h1234, 1'b0},
    '{12'h014, 32'h100020, 32'h100020, 1'b0}, '{12'h018, 32'h8, 32'h8, 1'b0},
    '{12'h024, 32'hffffffff, 32'h0, 1'b1}};
  atc_top #(.TICK_CYC(4)) uut (.clock_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .phase_a_i, .relay_closed_i, .local_panel_i,
    .sample_i, .list_done_i, .trigger_o, .capture_o, .pretrig_buffer_o, .volt_a_o, .volt_b_o,
    .volt_c_o, .volt_slew_o, .freq_slew_o, .transient_go_o, .list_step_o, .phase_b_o, .phase_c_o);
  atc_apb_master u_mst (.clock_i, .rst_b_i, .req_i(req), .wr_i(wr), .addr_i(addr),
    .wdata_i(wdat), .pready_i(pready_o), .pslverr_i(pslverr_o), .prdata_i(prdata_o),
    .psel_o(psel_i), .penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i),
    .pwdata_o(pwdata_i), .rdata_o(rdata), .err_o(err), .done_o(done));
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    capt_q <= capture_o;
    if (spin) phase_a_i <= (phase_a_i == 9'd350) ? 9'd0 : phase_a_i + 9'd10;
    if (trigger_o === 1'b1) begin
      n_trig <= n_trig + 1;
      t_trig <= cyc;
    end
    if (capture_o === 1'b1 && capt_q !== 1'b1) begin
      n_capt <= n_capt + 1;
      t_capt <= cyc;
    end
    if (transient_go_o === 1'b1) n_go <= n_go + 1;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      num_errors++;
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_i);
    req <= 1'b1;
    wr <= w;
    addr <= a;
    wdat <= d;
    for (int i = 0; i < 20 && done !== 1'b1; i++) @(posedge clock_i);
    chk("bus done", 32'h1, {31'h0, done});
    if (done !== 1'b1) complete_run();
    req <= 1'b0;
    rd = rdata;
    er = err;
  endtask
  task automatic wait_ev(input bit c, input int base, input int lim);
    for (int i = 0; i < lim && (c ? n_capt : n_trig) <= base; i++) @(posedge clock_i);
    chk(c ? "capture" : "trigger", 32'h1, 32'((c ? n_capt : n_trig) > base));
    if ((c ? n_capt : n_trig) <= base) complete_run();
  endtask
  task automatic end_capt(input int base);
    wait_ev(1'b1, base, 40);
    @(posedge clock_i);
    sample_i <= 1'b1;
    @(posedge clock_i);
    sample_i <= 1'b0;
  endtask
  initial begin
    num_errors = 0;
    num_checks = 0;
    {rst_b_i, req, wr, addr, wdat, relay_closed_i, local_panel_i, sample_i} = '0;
    {list_done_i, spin, capt_q} = '0;
    phase_a_i = 9'd100;
    repeat (16) @(posedge clock_i);
    chk("reset slew", 32'hffffffff, {volt_slew_o, freq_slew_o});
    rst_b_i <= 1'b1;
    foreach (rows[k]) begin
      bus(1'b1, rows[k].a, rows[k].w);
      bus(1'b0, rows[k].a, 32'h0);
      chk("read", rows[k].x, rd);
      chk("error", {31'h0, rows[k].e}, {31'h0, er});
    end
    chk("fixed volt", 32'h1234, {16'h0, volt_a_o});
    chk("slew regs", 32'h00200010, {volt_slew_o, freq_slew_o});
    local_panel_i <= 1'b1;
    repeat (5) @(posedge clock_i);
    chk("panel slew", 32'hffffffff, {volt_slew_o, freq_slew_o});
    local_panel_i <= 1'b0;
    nt = n_trig;
    nc = n_capt;
    bus(1'b1, 12'h000, 32'h1);
    wait_ev(1'b0, nt, 10);
    wait_ev(1'b1, nc, 40);
    chk("hold-off", 32'h1, 32'(t_capt - t_trig >= 8 && t_capt - t_trig <= 15));
    end_capt(nc);
    bus(1'b0, 12'h01c, 32'h0);
    chk("idle", 32'h0, {30'h0, rd[1:0]});
    chk("one trigger", nt + 1, n_trig);
    chk("phase b c", {9'd335, 9'd215}, {phase_b_o, phase_c_o});
    spin <= 1'b1;
    nt = n_trig;
    nc = n_capt;
    bus(1'b1, 12'h000, 32'h5);
    repeat (20) @(posedge clock_i);
    chk("early phase", nt, n_trig);
    wait_ev(1'b0, nt, 40);
    end_capt(nc);
    spin <= 1'b0;
    nt = n_trig;
    nc = n_capt;
    bus(1'b1, 12'h000, 32'h109);
    repeat (20) @(posedge clock_i);
    chk("relay open", nt, n_trig);
    chk("volt kept", 32'h1234, {16'h0, volt_a_o});
    relay_closed_i <= 1'b1;
    wait_ev(1'b0, nt, 10);
    chk("step a b", 32'h05551234, {volt_a_o, volt_b_o});
    end_capt(nc);
    bus(1'b1, 12'h00c, 32'h777);
    nt = n_trig;
    nc = n_capt;
    bus(1'b1, 12'h000, 32'h1c9);
    wait_ev(1'b0, nt, 10);
    chk("step all", {volt_a_o, volt_a_o}, {volt_b_o, volt_c_o});
    chk("step a", 32'h0777, {16'h0, volt_a_o});
    end_capt(nc);
    bus(1'b1, 12'h00c, 32'haa);
    nc = n_capt;
    bus(1'b1, 12'h000, 32'h29);
    wait_ev(1'b1, nc, 40);
    chk("pulse on", 32'haa, {16'h0, volt_a_o});
    end_capt(nc);
    repeat (30) @(posedge clock_i);
    chk("pulse off", 32'h777, {16'h0, volt_a_o});
    for (int m = 0; m < 4; m++) begin
      ng = n_go;
      nt = n_trig;
      nc = n_capt;
      bus(1'b1, 12'h000, 32'h1 | (m << 4));
      wait_ev(1'b0, nt, 10);
      chk("go", 32'(m == 1), n_go - ng);
      if (m == 3) chk("list", 32'h1, {31'h0, list_step_o});
      end_capt(nc);
    end
    list_done_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    chk("list end", 32'h0, {31'h0, list_step_o});
    bus(1'b1, 12'h004, 32'hfe0c);
    bus(1'b1, 12'h000, 32'h5);
    chk("pretrig", 32'h1, {31'h0, pretrig_buffer_o});
    bus(1'b1, 12'h000, 32'h5);
    bus(1'b0, 12'h01c, 32'h0);
    chk("rearmed", 32'h1, {30'h0, rd[1:0]});
    nt = n_trig;
    bus(1'b1, 12'h000, 32'hd);
    repeat (10) @(posedge clock_i);
    chk("reserved source", nt, n_trig);
    bus(1'b1, 12'h004, 32'h3);
    nt = n_trig;
    nc = n_capt;
    bus(1'b1, 12'h000, 32'h3);
    end_capt(nc);
    wait_ev(1'b0, nt + 1, 20);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    chk("second reset", 32'hffffffff, {volt_slew_o, freq_slew_o});
    chk("idle outputs", 32'h0, {29'h0, trigger_o, capture_o, pretrig_buffer_o});
    complete_run();
  end
endmodule
